// file: src/boot_stream_loader.sv
`timescale 1ns/1ps
`default_nettype none
module boot_stream_loader
    import bsl_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic stream_valid_i,
    input wire logic [15:0] stream_data_i,
    output logic stream_ready_o,
    output logic mem_we_o,
    output logic [31:0] mem_addr_o,
    output logic [15:0] mem_data_o,
    output logic [31:0] start_location_o,
    output logic done_o,
    output logic error_o
);
    // States in which values go through the word assembler
    function automatic logic word_phase(input bsl_state_t st);
        case (st)
            BSL_ST_RSVD, BSL_ST_ENT_HI, BSL_ST_ENT_LO, BSL_ST_SIZE,
            BSL_ST_DST_HI, BSL_ST_DST_LO, BSL_ST_DATA: word_phase = 1'b1;
            default: word_phase = 1'b0;
        endcase
    endfunction

    function automatic logic consuming(input bsl_state_t st);
        consuming = word_phase(st) || st == BSL_ST_KEY0 || st == BSL_ST_KEY1;
    endfunction

    bsl_ctl_t c_q;
    bsl_ctl_t c_d;
    logic take;

    bsl_word_if w();

    assign take = stream_valid_i && c_q.in_ready;
    assign w.val_valid = take && word_phase(c_q.st);
    assign w.val_data = stream_data_i;
    assign w.byte_mode = c_q.byte_mode;

    bsl_word_asm u_asm (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .w(w)
    );

    always_comb begin
        c_d = c_q;
        c_d.mem_we = 1'b0;
        case (c_q.st)
            BSL_ST_KEY0: begin
                if (take) begin
                    if (stream_data_i == BSL_WORD_KEY) begin // RULE1 RULE12
                        c_d.byte_mode = 1'b0;
                        c_d.rsvd_cnt = BSL_RSVD_WORDS;
                        c_d.st = BSL_ST_RSVD;
                    end else begin
                        c_d.first = stream_data_i[7:0];
                        c_d.st = BSL_ST_KEY1;
                    end
                end
            end
            BSL_ST_KEY1: begin
                if (take) begin
                    if ({stream_data_i[7:0], c_q.first} == BSL_BYTE_KEY) begin // RULE9 RULE12
                        c_d.byte_mode = 1'b1;
                        c_d.rsvd_cnt = BSL_RSVD_WORDS;
                        c_d.st = BSL_ST_RSVD;
                    end else begin
                        c_d.st = BSL_ST_ABORT; // RULE12
                    end
                end
            end
            BSL_ST_RSVD: begin
                if (w.word_valid) begin
                    // Value discarded, only counted
                    c_d.rsvd_cnt = c_q.rsvd_cnt - 4'h1; // RULE2
                    if (c_q.rsvd_cnt == 4'h1) begin
                        c_d.st = BSL_ST_ENT_HI;
                    end
                end
            end
            BSL_ST_ENT_HI: begin
                if (w.word_valid) begin
                    c_d.entry[31:16] = w.word_data; // RULE8
                    // A nonzero top byte cannot be a legal start location
                    if (w.word_data[15:8] != BSL_ENTRY_TOP) begin // RULE3
                        c_d.st = BSL_ST_ABORT;
                    end else begin
                        c_d.st = BSL_ST_ENT_LO;
                    end
                end
            end
            BSL_ST_ENT_LO: begin
                if (w.word_valid) begin
                    c_d.entry[15:0] = w.word_data; // RULE3
                    c_d.st = BSL_ST_SIZE;
                end
            end
            BSL_ST_SIZE: begin
                if (w.word_valid) begin
                    c_d.blk_cnt = w.word_data; // RULE5
                    if (w.word_data == BSL_END_SIZE) begin // RULE4
                        c_d.start = c_q.entry; // RULE11
                        c_d.done = 1'b1;
                        c_d.st = BSL_ST_DONE;
                    end else begin
                        c_d.st = BSL_ST_DST_HI;
                    end
                end
            end
            BSL_ST_DST_HI: begin
                if (w.word_valid) begin
                    c_d.dest[31:16] = w.word_data; // RULE8 RULE10
                    c_d.st = BSL_ST_DST_LO;
                end
            end
            BSL_ST_DST_LO: begin
                if (w.word_valid) begin
                    c_d.dest[15:0] = w.word_data; // RULE10
                    c_d.st = BSL_ST_DATA;
                end
            end
            BSL_ST_DATA: begin
                if (w.word_valid) begin
                    c_d.mem_we = 1'b1; // RULE6
                    c_d.mem_addr = c_q.dest;
                    c_d.mem_data = w.word_data;
                    c_d.dest = c_q.dest + 32'h1; // RULE6
                    c_d.blk_cnt = c_q.blk_cnt - BSL_ONE_WORD; // RULE5
                    if (c_q.blk_cnt == BSL_ONE_WORD) begin
                        c_d.st = BSL_ST_SIZE;
                    end
                end
            end
            BSL_ST_DONE: begin
                c_d.done = 1'b1;
            end
            BSL_ST_ABORT: begin
                c_d.err = 1'b1; // RULE13
            end
            default: begin
                c_d.st = BSL_ST_ABORT;
            end
        endcase
        if (c_d.st == BSL_ST_ABORT) begin
            c_d.err = 1'b1; // RULE13
            c_d.mem_we = 1'b0;
        end
        // Ready drops as soon as the stream is finished or rejected
        c_d.in_ready = consuming(c_d.st); // RULE13
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            c_q <= '0;
            c_q.st <= BSL_ST_KEY0;
        end else begin
            c_q <= c_d;
        end
    end

    assign stream_ready_o = c_q.in_ready;
    assign mem_we_o = c_q.mem_we;
    assign mem_addr_o = c_q.mem_addr;
    assign mem_data_o = c_q.mem_data;
    assign start_location_o = c_q.start;
    assign done_o = c_q.done;
    assign error_o = c_q.err;
endmodule
`default_nettype wire

// file: src/bsl_pkg.sv
// Behaviour
// [RULE1] Word-wide stream opens with width key 0x10AA selecting 16-bit operation.
// [RULE2] Eight reserved words follow the key; each is read and discarded.
// [RULE3] 32-bit entry address follows; its top byte must be 0x00.
// [RULE4] Each block starts with a size; size zero ends the stream.
// [RULE5] Block size counts 16-bit words in both widths; byte mode takes two bytes each.
// [RULE6] Destination address follows size; data words stored at consecutive locations.
// [RULE7] Byte mode assembles each word low byte first, high byte second.
// [RULE8] 32-bit values arrive high word first, then low word.
// [RULE9] Byte-mode stream opens with bytes AA then 08, forming key 0x08AA.
// [RULE10] Byte-mode address bytes arrive 23:16, 31:24, 7:0, 15:8 into place.
// [RULE11] After the zero size, captured entry address is presented as start location.
// [RULE12] First value checked against word key, else paired with second against byte key.
// [RULE13] Abort raises error, writes nothing, stops consuming until reset.
package bsl_pkg;
    localparam logic [15:0] BSL_WORD_KEY = 16'h10aa;
    localparam logic [15:0] BSL_BYTE_KEY = 16'h08aa;
    localparam logic [3:0] BSL_RSVD_WORDS = 4'h8;
    localparam logic [15:0] BSL_END_SIZE = 16'h0000;
    localparam logic [15:0] BSL_ONE_WORD = 16'h0001;
    localparam logic [7:0] BSL_ENTRY_TOP = 8'h00;

    typedef enum logic [3:0] {
        BSL_ST_KEY0 = 4'h0,
        BSL_ST_KEY1 = 4'h1,
        BSL_ST_RSVD = 4'h2,
        BSL_ST_ENT_HI = 4'h3,
        BSL_ST_ENT_LO = 4'h4,
        BSL_ST_SIZE = 4'h5,
        BSL_ST_DST_HI = 4'h6,
        BSL_ST_DST_LO = 4'h7,
        BSL_ST_DATA = 4'h8,
        BSL_ST_DONE = 4'h9,
        BSL_ST_ABORT = 4'ha
    } bsl_state_t;

    typedef struct packed {
        logic half;
        logic [7:0] lo;
        logic vld;
        logic [15:0] word;
    } bsl_asm_t;

    typedef struct packed {
        bsl_state_t st;
        logic byte_mode;
        logic [7:0] first;
        logic [3:0] rsvd_cnt;
        logic [15:0] blk_cnt;
        logic [31:0] entry;
        logic [31:0] dest;
        logic in_ready;
        logic mem_we;
        logic [31:0] mem_addr;
        logic [15:0] mem_data;
        logic done;
        logic err;
        logic [31:0] start;
    } bsl_ctl_t;
endpackage

// file: src/bsl_word_asm.sv
`timescale 1ns/1ps
`default_nettype none
module bsl_word_asm
    import bsl_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    bsl_word_if.asm w
);
    bsl_asm_t s_q;
    bsl_asm_t s_d;

    always_comb begin
        s_d = s_q;
        s_d.vld = 1'b0;
        if (w.val_valid) begin
            if (w.byte_mode) begin
                if (!s_q.half) begin
                    s_d.lo = w.val_data[7:0]; // RULE7
                    s_d.half = 1'b1;
                end else begin
                    s_d.word = {w.val_data[7:0], s_q.lo}; // RULE7
                    s_d.vld = 1'b1;
                    s_d.half = 1'b0;
                end
            end else begin
                s_d.word = w.val_data;
                s_d.vld = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign w.word_valid = s_q.vld;
    assign w.word_data = s_q.word;
endmodule
`default_nettype wire

// file: src/bsl_word_if.sv
`timescale 1ns/1ps
`default_nettype none
interface bsl_word_if;
    logic val_valid;
    logic [15:0] val_data;
    logic byte_mode;
    logic word_valid;
    logic [15:0] word_data;

    modport asm (
        input val_valid,
        input val_data,
        input byte_mode,
        output word_valid,
        output word_data
    );
    modport ctl (
        output val_valid,
        output val_data,
        output byte_mode,
        input word_valid,
        input word_data
    );
endinterface
`default_nettype wire

// file: test/bsl_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module bsl_assertions (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic stream_valid_i,
    input wire logic [15:0] stream_data_i,
    input wire logic stream_ready_o,
    input wire logic mem_we_o,
    input wire logic [31:0] mem_addr_o,
    input wire logic [15:0] mem_data_o,
    input wire logic [31:0] start_location_o,
    input wire logic done_o,
    input wire logic error_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    sequence s_two_wr;
        mem_we_o ##1 mem_we_o;
    endsequence
    sequence s_rel;
        $fell(rst_i);
    endsequence
    property p_addr_inc; s_two_wr |-> mem_addr_o == $past(mem_addr_o) + 32'h1; endproperty
    a_addr_inc: assert property (p_addr_inc) else $error("write address not consecutive");
    property p_err_nowr; error_o |-> !mem_we_o; endproperty
    a_err_nowr: assert property (p_err_nowr) else $error("write after abort");
    property p_err_stop; error_o |-> !stream_ready_o; endproperty
    a_err_stop: assert property (p_err_stop) else $error("stream taken after abort");
    property p_err_hold; error_o |=> error_o; endproperty
    a_err_hold: assert property (p_err_hold) else $error("error flag dropped");
    property p_done_hold; done_o |=> done_o && $stable(start_location_o); endproperty
    a_done_hold: assert property (p_done_hold) else $error("start location not held");
    property p_start_0; !done_o |-> start_location_o == 32'h0; endproperty
    a_start_0: assert property (p_start_0) else $error("start location shown early");
    property p_done_stop; done_o |-> !stream_ready_o && !error_o; endproperty
    a_done_stop: assert property (p_done_stop) else $error("stream taken after end");
    property p_rel; s_rel |-> !stream_ready_o ##1 stream_ready_o; endproperty
    a_rel: assert property (p_rel) else $error("not ready for key after reset");
endmodule
`default_nettype wire

// file: test/bsl_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module bsl_host_model (
    input wire logic clk_i,
    input wire logic ready_i,
    output logic valid_o,
    output logic [15:0] data_o
);
    initial begin
        valid_o = 1'b0;
        data_o = 16'h0;
    end
    // Value held until an edge samples ready high or 40 edges pass; caller fixes the order
    task automatic put(input logic [15:0] v);
        int n;
        logic r;
        n = 0;
        @(negedge clk_i);
        valid_o = 1'b1;
        data_o = v;
        do begin
            r = ready_i;
            @(posedge clk_i);
            n++;
        end while (r !== 1'b1 && n < 40);
    endtask
    // Released bus shows inverted data so a stale capture cannot pass
    task automatic idle();
        @(negedge clk_i);
        valid_o = 1'b0;
        data_o = ~data_o;
    endtask
endmodule
`default_nettype wire

// file: test/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic valid, ready, we, done, err;
    logic [15:0] data, wdata;
    logic [31:0] waddr, start, e;
    logic [15:0] s[$];
    logic [47:0] exp[$];
    int fail_count = 0;
    int n_tests = 0;
    always #2.5 clk_i = ~clk_i;
    boot_stream_loader dut (.clk_i(clk_i), .rst_i(rst_i), .stream_valid_i(valid), .stream_data_i(data),
        .stream_ready_o(ready), .mem_we_o(we), .mem_addr_o(waddr), .mem_data_o(wdata),
        .start_location_o(start), .done_o(done), .error_o(err));
    bsl_host_model host (.clk_i(clk_i), .ready_i(ready), .valid_o(valid), .data_o(data));
    task automatic print_verdict();
        if (fail_count == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [47:0] got, input logic [47:0] want);
        n_tests++;
        if (got !== want) begin
            fail_count++;
            $display("Error at %0t: got %h, want %h", $time, got, want);
        end
    endtask
    task automatic reset();
        @(negedge clk_i);
        rst_i = 1'b1;
        repeat (6) @(negedge clk_i);
        rst_i = 1'b0;
    endtask
    task automatic mk(input logic [15:0] key, input logic [31:0] ent);
        s = {key};
        exp.delete();
        repeat (int'(bsl_pkg::BSL_RSVD_WORDS)) s.push_back(16'($urandom));
        s.push_back(ent[31:16]);
        s.push_back(ent[15:0]);
    endtask
    task automatic blk(input logic [31:0] a, input int n);
        s.push_back(16'(n));
        s.push_back(a[31:16]);
        s.push_back(a[15:0]);
        for (int i = 0; i < n; i++) begin
            s.push_back(16'($urandom));
            exp.push_back({a + 32'(i), s[$]});
        end
    endtask
    task automatic run(input bit bm, input bit gaps);
        s.push_back(16'h0);
        foreach (s[i]) begin
            if (bm) begin
                // High byte kept off 0x10 so the first key byte never reads as the word key
                host.put({8'($urandom) | 8'h80, s[i][7:0]});
                host.put({8'($urandom), s[i][15:8]});
            end else begin
                host.put(s[i]);
            end
            if (gaps && $urandom_range(3) == 0) host.idle();
        end
        host.idle();
    endtask
    task automatic fin(input logic [1:0] de, input logic [31:0] ent);
        for (int i = 0; i < 40 && done !== 1'b1; i++) @(negedge clk_i);
        chk(48'({err, done, ready}), 48'({de, 1'b0}));
        chk(48'(start), 48'(ent));
        chk(48'(exp.size()), 48'h0);
    endtask
    always @(negedge clk_i) begin
        if (we === 1'b1) begin
            if (exp.size() == 0) chk(48'h1, 48'h0);
            else chk({waddr, wdata}, exp.pop_front());
        end
    end
    initial begin
        #50us;
        fail_count++;
        print_verdict();
    end
    initial begin
        void'($urandom(32'ha1a9));
        reset();
        mk(bsl_pkg::BSL_WORD_KEY, 32'h003f8000);
        blk(32'h003f9010, 5);
        blk(32'hfffffffe, 3);
        run(1'b0, 1'b0);
        fin(2'b01, 32'h003f8000);
        reset();
        e = {8'h00, 24'($urandom)};
        mk(bsl_pkg::BSL_BYTE_KEY, e);
        blk(32'($urandom), 1);
        blk(32'($urandom), 4);
        run(1'b1, 1'b1);
        fin(2'b01, e);
        reset();
        mk(16'h10ab, 32'h0);
        run(1'b0, 1'b0);
        fin(2'b10, 32'h0);
        reset();
        mk(bsl_pkg::BSL_WORD_KEY, 32'h01000000);
        blk(32'h00001000, 2);
        exp.delete();
        run(1'b0, 1'b0);
        fin(2'b10, 32'h0);
        print_verdict();
    end
endmodule
bind boot_stream_loader bsl_assertions u_chk (.clk_i(clk_i), .rst_i(rst_i), .stream_valid_i(stream_valid_i),
    .stream_data_i(stream_data_i), .stream_ready_o(stream_ready_o), .mem_we_o(mem_we_o),
    .mem_addr_o(mem_addr_o), .mem_data_o(mem_data_o), .start_location_o(start_location_o),
    .done_o(done_o), .error_o(error_o));
`default_nettype wire
